// ### bfr_defs.vh
// Constants for the bus fault recovery frame unit.
`ifndef BFR_DEFS_VH
`define BFR_DEFS_VH
// Saved fault status word bit positions.
`define BFR_ST_TP 15
`define BFR_ST_CONT 14
`define BFR_ST_RERUN 9
`define BFR_ST_RW 6
// Transfer count base for a multi register move.
`define BFR_MOVE_BASE 8'h10
// Bus error frame offsets in bytes from the stack pointer.
`define BFR_OFS_RETPC 8'h02
`define BFR_OFS_SR 8'h0C
`define BFR_OFS_FV 8'h0E
`define BFR_OFS_FPC 8'h10
`define BFR_OFS_COUNT 8'h14
`define BFR_OFS_INNER 8'h06
// Frame sizes in words.
`define BFR_WORDS_FOUR 4'h4
`define BFR_WORDS_SIX 4'h6
`define BFR_WORDS_FAULT 4'hC
// Fault kinds.
`define BFR_FK_INSTR 2'h0
`define BFR_FK_MOVE 2'h1
`define BFR_FK_EXC 2'h2
// Exception classes.
`define BFR_EX_IRQ 3'h0
`define BFR_EX_FMT 3'h1
`define BFR_EX_TRAP 3'h2
`define BFR_EX_ILL 3'h3
`define BFR_EX_LINEA 3'h4
`define BFR_EX_LINEF 3'h5
`define BFR_EX_PRIV 3'h6
`define BFR_EX_INSTR 3'h7
`endif

// ### bfr_frame_unit.v
// Bus fault recovery: fault frame building and return-from-exception decisions.
`timescale 1ns/1ns
`default_nettype none
`include "bfr_defs.vh"
// Behaviour
// RULE_01 - Return tests rerun flag only, never direction
// RULE_02 - Type II aborted instruction refetched, restarted
// RULE_03 - Saved move count is sixteen minus transfers
// RULE_04 - Cleared continue flag restarts move, no undo
// RULE_05 - Restart recomputes address from current registers
// RULE_06 - Unaltered move frame resumes at faulted transfer
// RULE_07 - Only the register move continues mid-way
// RULE_08 - Continue keeps address, rescans mask same count
// RULE_09 - Vector and stacking faults share frame, word
// RULE_10 - Vector fault records format word address
// RULE_11 - Return refetches handler, rebuilds frame, resumes
// RULE_12 - Frame offsets 0C, 0E, 10 and 02
// RULE_13 - Faulted frame rebuilt at offset 14 plus 06
// RULE_14 - Completed fault stacking records current stack pointer
// RULE_15 - Only four, six and twelve word frames
// RULE_16 - Four-word frame classes, saved counter by type
module bfr_frame_unit (
    // Clock, reset and clock enable.
    input wire core_clk,
    input wire rst_b,
    input wire clkEn,
    // Bus fault capture.
    input wire faultReq,
    input wire [1:0] faultKind,
    input wire faultWrite,
    input wire [31:0] faultAddr,
    input wire [4:0] moveAttempts,
    input wire vecFetchFault,
    input wire faultStackOk,
    input wire [31:0] curSp,
    input wire [31:0] fvWordAddr,
    input wire [15:0] preSr,
    input wire [15:0] fmtVec,
    input wire [31:0] faultPc,
    input wire [31:0] retPc,
    // Bus error frame word writes.
    output reg frmWrValid,
    input wire frmWrReady,
    output reg [7:0] frmWrOfs,
    output reg [31:0] frmWrData,
    output reg [15:0] savedStatus,
    output reg [7:0] savedCount,
    output reg [31:0] savedFaultAddr,
    output wire [7:0] rebuildOfs,
    // Normal exception frames.
    input wire excReq,
    input wire [2:0] excClass,
    input wire [31:0] nextPc,
    input wire [31:0] instrPc,
    output reg [3:0] frameWords,
    output reg [31:0] savedPc,
    // Return from exception.
    input wire excRetReq,
    input wire [15:0] retStatus,
    input wire [7:0] retCount,
    output reg rerunReq,
    output reg rerunDiscard,
    output reg restartReq,
    output reg recomputeEa,
    output reg continueReq,
    output reg [4:0] rescanCount,
    output reg vectorFetchReq,
    output reg buildFrameReq,
    output reg resumeReq,
    output wire busy
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Frame size for a normal exception class.
    function [3:0] frameSize;
        input [2:0] cls;
        begin
            if (cls == `BFR_EX_INSTR) begin
                frameSize = `BFR_WORDS_SIX; // [RULE_15]
            end else begin
                frameSize = `BFR_WORDS_FOUR; // [RULE_16]
            end
        end
    endfunction

    // Remaining count against the move base.
    function [7:0] fromBase;
        input [7:0] val;
        begin
            fromBase = `BFR_MOVE_BASE - val;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WRITE = 2'h1;
    localparam [2:0] RT_IDLE = 3'h0;
    localparam [2:0] RT_DECIDE = 3'h1;
    localparam [2:0] RT_RERUN = 3'h2;
    localparam [2:0] RT_VECTOR = 3'h3;
    localparam [2:0] RT_BUILD = 3'h4;
    localparam [2:0] RT_RESUME = 3'h5;

    reg [1:0] stState_reg;
    reg [1:0] stIdx_reg;
    reg [15:0] frmSr_reg;
    reg [15:0] frmFv_reg;
    reg [31:0] frmFpc_reg;
    reg [31:0] frmRpc_reg;
    reg [2:0] rtState_reg;
    reg [15:0] rtStatus_reg;
    reg [7:0] rtCount_reg;
    wire [8:0] rebuildSum;
    wire [7:0] rescanFull;

    // The faulted exception frame sits above the twelve words.
    assign rebuildSum = {1'b0, `BFR_OFS_COUNT} + {1'b0, `BFR_OFS_INNER};
    assign rebuildOfs = rebuildSum[7:0]; // [RULE_13]
    // Transfers made before the fault; a count above sixteen is corrupt and is capped below.
    assign rescanFull = fromBase(rtCount_reg);
    assign busy = (stState_reg != ST_IDLE) || (rtState_reg != RT_IDLE);

    // ------------------------------------------------------------
    // Fault capture and bus error frame stacking
    // ------------------------------------------------------------

    // Latch the saved status, count and fault address; exception-processing faults then emit frame words.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stState_reg <= ST_IDLE;
            stIdx_reg <= 2'h0;
            frmSr_reg <= 16'h0000;
            frmFv_reg <= 16'h0000;
            frmFpc_reg <= 32'h0000_0000;
            frmRpc_reg <= 32'h0000_0000;
            frmWrValid <= 1'b0;
            frmWrOfs <= 8'h00;
            frmWrData <= 32'h0000_0000;
            savedStatus <= 16'h0000;
            savedCount <= 8'h00;
            savedFaultAddr <= 32'h0000_0000;
        end else if (clkEn) begin
            case (stState_reg)
                ST_IDLE: begin
                    frmWrValid <= 1'b0;
                    if (faultReq) begin
                        savedStatus <= 16'h0000;
                        savedCount <= 8'h00;
                        savedFaultAddr <= faultAddr;
                        if (faultKind == `BFR_FK_MOVE) begin
                            savedStatus[`BFR_ST_CONT] <= 1'b1;
                            savedStatus[`BFR_ST_RERUN] <= faultWrite;
                            savedStatus[`BFR_ST_RW] <= ~faultWrite;
                            savedCount <= fromBase({3'h0, moveAttempts}); // [RULE_03]
                        end else if (faultKind == `BFR_FK_EXC) begin
                            // Vector and stacking faults get one word; the address tells them apart.
                            savedStatus[`BFR_ST_TP] <= 1'b1; // [RULE_09]
                            savedStatus[`BFR_ST_RW] <= 1'b1;
                            if (vecFetchFault) begin
                                savedFaultAddr <= fvWordAddr; // [RULE_10]
                            end else if (faultStackOk) begin
                                savedFaultAddr <= curSp; // [RULE_14]
                            end
                            frmSr_reg <= preSr;
                            frmFv_reg <= fmtVec;
                            frmFpc_reg <= faultPc;
                            frmRpc_reg <= retPc;
                            frmWrValid <= 1'b1;
                            frmWrOfs <= `BFR_OFS_SR; // [RULE_12]
                            frmWrData <= {16'h0000, preSr};
                            stIdx_reg <= 2'h0;
                            stState_reg <= ST_WRITE;
                        end else begin
                            savedStatus[`BFR_ST_RERUN] <= faultWrite;
                            savedStatus[`BFR_ST_RW] <= ~faultWrite;
                        end
                    end
                end
                ST_WRITE: begin
                    // Words advance only when the stacking side accepts them.
                    if (frmWrReady) begin
                        stIdx_reg <= stIdx_reg + 2'h1;
                        case (stIdx_reg)
                            2'h0: begin
                                frmWrOfs <= `BFR_OFS_FV; // [RULE_12]
                                frmWrData <= {16'h0000, frmFv_reg};
                            end
                            2'h1: begin
                                frmWrOfs <= `BFR_OFS_FPC; // [RULE_12]
                                frmWrData <= frmFpc_reg;
                            end
                            2'h2: begin
                                frmWrOfs <= `BFR_OFS_RETPC; // [RULE_12]
                                frmWrData <= frmRpc_reg;
                            end
                            default: begin
                                frmWrValid <= 1'b0;
                                stState_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    stState_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Normal frame selection
    // ------------------------------------------------------------

    // A fault frame overrides; otherwise the class picks four or six words.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frameWords <= 4'h0;
            savedPc <= 32'h0000_0000;
        end else if (clkEn) begin
            if (faultReq) begin
                frameWords <= `BFR_WORDS_FAULT; // [RULE_15]
            end else if (excReq) begin
                frameWords <= frameSize(excClass);
                // Asynchronous and trap classes return past the instruction.
                case (excClass)
                    `BFR_EX_IRQ, `BFR_EX_TRAP, `BFR_EX_INSTR: begin
                        savedPc <= nextPc; // [RULE_16]
                    end
                    default: begin
                        savedPc <= instrPc; // [RULE_16]
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Return from exception
    // ------------------------------------------------------------

    // Each request output is a one-cycle pulse in a fixed order after the request; rerunDiscard and rescanCount hold their values.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rtState_reg <= RT_IDLE;
            rtStatus_reg <= 16'h0000;
            rtCount_reg <= 8'h00;
            rerunReq <= 1'b0;
            rerunDiscard <= 1'b0;
            restartReq <= 1'b0;
            recomputeEa <= 1'b0;
            continueReq <= 1'b0;
            rescanCount <= 5'h00;
            vectorFetchReq <= 1'b0;
            buildFrameReq <= 1'b0;
            resumeReq <= 1'b0;
        end else if (clkEn) begin
            rerunReq <= 1'b0;
            restartReq <= 1'b0;
            recomputeEa <= 1'b0;
            continueReq <= 1'b0;
            vectorFetchReq <= 1'b0;
            buildFrameReq <= 1'b0;
            resumeReq <= 1'b0;
            case (rtState_reg)
                RT_IDLE: begin
                    if (excRetReq) begin
                        rtStatus_reg <= retStatus;
                        rtCount_reg <= retCount;
                        rtState_reg <= RT_DECIDE;
                    end
                end
                RT_DECIDE: begin
                    if (rtStatus_reg[`BFR_ST_TP]) begin
                        vectorFetchReq <= 1'b1; // [RULE_11]
                        rtState_reg <= RT_VECTOR;
                    end else if (rtStatus_reg[`BFR_ST_RERUN]) begin
                        // Direction is not checked; a read rerun just drops its data.
                        rerunReq <= 1'b1; // [RULE_01]
                        rerunDiscard <= rtStatus_reg[`BFR_ST_RW]; // [RULE_01]
                        rtState_reg <= RT_RERUN;
                    end else begin
                        rtState_reg <= RT_RERUN;
                    end
                end
                RT_RERUN: begin
                    rtState_reg <= RT_IDLE;
                    if (rtStatus_reg[`BFR_ST_CONT]) begin
                        // The address is kept and the mask is rescanned as before.
                        continueReq <= 1'b1; // [RULE_06] [RULE_07] [RULE_08]
                        rescanCount <= (rescanFull > 8'h10) ? 5'h10 : rescanFull[4:0]; // [RULE_08]
                    end else begin
                        // Completed transfers are not undone; stale registers give a wrong address.
                        restartReq <= 1'b1; // [RULE_02] [RULE_04]
                        recomputeEa <= 1'b1; // [RULE_05]
                    end
                end
                RT_VECTOR: begin
                    buildFrameReq <= 1'b1; // [RULE_11]
                    rtState_reg <= RT_BUILD;
                end
                RT_BUILD: begin
                    resumeReq <= 1'b1; // [RULE_11]
                    rtState_reg <= RT_RESUME;
                end
                RT_RESUME: begin
                    rtState_reg <= RT_IDLE;
                end
                default: begin
                    rtState_reg <= RT_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### bfr_frame_unit_props.sv
// Assertion checker for the bus fault recovery frame unit.
`timescale 1ns/1ns
`default_nettype none
module bfr_frame_unit_props (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Requests.
    input wire logic faultReq,
    input wire logic [1:0] faultKind,
    input wire logic excRetReq,
    input wire logic [15:0] retStatus,
    input wire logic [7:0] retCount,
    // Frame word writes.
    input wire logic frmWrValid,
    input wire logic frmWrReady,
    input wire logic [7:0] frmWrOfs,
    // Return decisions.
    input wire logic rerunReq,
    input wire logic rerunDiscard,
    input wire logic restartReq,
    input wire logic recomputeEa,
    input wire logic continueReq,
    input wire logic [4:0] rescanCount,
    input wire logic vectorFetchReq,
    input wire logic buildFrameReq,
    input wire logic resumeReq,
    input wire logic busy
);
    // ----
    // Properties
    // ----
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A return is taken whenever the return machine is idle; go also needs stacking idle, so it marks a taken return.
    wire go = excRetReq && !busy && clkEn;
    AST_RET_EXC: assert property (go && retStatus[15]
        |-> ##2 vectorFetchReq ##1 buildFrameReq ##1 resumeReq)
        else $error("exception frame return order wrong");
    AST_RERUN: assert property (go && !retStatus[15] && retStatus[9]
        |-> ##2 rerunReq && rerunDiscard == $past(retStatus[6], 2))
        else $error("rerun missing or discard wrong");
    AST_NO_RERUN: assert property (go && !retStatus[15] && !retStatus[9] |-> ##2 !rerunReq)
        else $error("rerun without rerun flag");
    AST_CONT: assert property (go && retStatus[15:14] == 2'h1 && retCount <= 8'h10
        |-> ##3 continueReq && !restartReq && rescanCount == 5'(8'h10 - $past(retCount, 3)))
        else $error("continue or rescan count wrong");
    AST_RESTART: assert property (go && retStatus[15:14] == 2'h0
        |-> ##3 restartReq && recomputeEa && !continueReq)
        else $error("restart missing");
    AST_FRM_START: assert property (faultReq && faultKind == 2'h2 && !busy && clkEn
        |=> frmWrValid && frmWrOfs == 8'h0C)
        else $error("fault frame does not start at status word");
    AST_FRM_HOLD: assert property (frmWrValid && !frmWrReady && clkEn
        |=> frmWrValid && $stable(frmWrOfs))
        else $error("frame word dropped before acceptance");
    AST_FRM_NEXT: assert property (frmWrValid && frmWrReady && clkEn
        |=> if ($past(frmWrOfs) == 8'h02) !frmWrValid
        else (frmWrValid && frmWrOfs == ($past(frmWrOfs) == 8'h0C ? 8'h0E : $past(frmWrOfs) == 8'h0E ? 8'h10 : 8'h02)))
        else $error("frame word order wrong");
endmodule
bind bfr_frame_unit bfr_frame_unit_props u_bfr_frame_unit_props (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .faultReq(faultReq),
    .faultKind(faultKind),
    .excRetReq(excRetReq),
    .retStatus(retStatus),
    .retCount(retCount),
    .frmWrValid(frmWrValid),
    .frmWrReady(frmWrReady),
    .frmWrOfs(frmWrOfs),
    .rerunReq(rerunReq),
    .rerunDiscard(rerunDiscard),
    .restartReq(restartReq),
    .recomputeEa(recomputeEa),
    .continueReq(continueReq),
    .rescanCount(rescanCount),
    .vectorFetchReq(vectorFetchReq),
    .buildFrameReq(buildFrameReq),
    .resumeReq(resumeReq),
    .busy(busy)
);
`default_nettype wire

// ### bfr_frame_unit_tb.sv
// Self-checking testbench for the bus fault recovery frame unit.
`timescale 1ns/1ns
`default_nettype none
module bfr_frame_unit_tb;
    // ----
    // Signals and model state
    // ----
    logic core_clk = 1'h0, rst_b = 1'h0, clkEn = 1'h1, faultReq = 1'h0, faultWrite = 1'h0;
    logic vecFetchFault = 1'h0, faultStackOk = 1'h0, frmWrReady = 1'h0, excReq = 1'h0, excRetReq = 1'h0;
    logic [1:0] faultKind = 2'h0;
    logic [4:0] moveAttempts = 5'h0;
    logic [2:0] excClass = 3'h0;
    logic [31:0] faultAddr = 32'h0, curSp = 32'h0, fvWordAddr = 32'h0, faultPc = 32'h0, retPc = 32'h0;
    logic [31:0] nextPc = 32'h0, instrPc = 32'h0;
    logic [15:0] preSr = 16'h0, fmtVec = 16'h0, retStatus = 16'h0, seed = 16'h5998;
    logic [7:0] retCount = 8'h0;
    logic frmWrValid, rerunReq, rerunDiscard, restartReq, recomputeEa, continueReq;
    logic vectorFetchReq, buildFrameReq, resumeReq, busy;
    logic [7:0] frmWrOfs, savedCount, rebuildOfs;
    logic [31:0] frmWrData, savedFaultAddr, savedPc;
    logic [15:0] savedStatus;
    logic [6:0] retPulses;
    logic [3:0] frameWords;
    logic [4:0] rescanCount;
    logic [39:0] q[$];
    int miscompares = 0, check_count = 0;
    bfr_frame_unit u_bfr_frame_unit (.*);
    // All return pulses in one word, in the order the model lists them.
    assign retPulses = {rerunReq, restartReq, recomputeEa, continueReq, vectorFetchReq, buildFrameReq, resumeReq};
    // Free-running core clock.
    always #10 core_clk = ~core_clk;
    // Sixteen-bit shift register source for all random stimulus.
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("check_count %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One fault pulse with fresh frame contents; returns in the answer cycle.
    task automatic fault(input logic [1:0] k, input int n, input logic v);
        @(posedge core_clk);
        faultReq <= 1'h1;
        faultKind <= k;
        moveAttempts <= n[4:0];
        vecFetchFault <= v;
        faultStackOk <= ~v;
        faultWrite <= seed[0];
        faultAddr <= {rnd(), rnd()};
        curSp <= {rnd(), rnd()};
        fvWordAddr <= {rnd(), rnd()};
        preSr <= rnd();
        fmtVec <= rnd();
        faultPc <= {rnd(), rnd()};
        retPc <= {rnd(), rnd()};
        @(posedge core_clk);
        faultReq <= 1'h0;
        @(negedge core_clk);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        int t;
        logic [6:0] e;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'h1;
        @(negedge core_clk);
        chk(rebuildOfs, 8'h1A);
        // Every exception class: frame size and which counter is saved.
        for (int c = 0; c < 8; c++) begin
            @(posedge core_clk);
            excReq <= 1'h1;
            excClass <= c[2:0];
            nextPc <= {rnd(), rnd()};
            instrPc <= {rnd(), rnd()};
            @(posedge core_clk);
            excReq <= 1'h0;
            @(negedge core_clk);
            chk(frameWords, (c == 7) ? 4'h6 : 4'h4);
            chk(savedPc, (c == 0 || c == 2 || c == 7) ? nextPc : instrPc);
        end
        // With the clock enable low a request is not taken and the frame size holds.
        @(posedge core_clk);
        clkEn <= 1'h0;
        excReq <= 1'h1;
        excClass <= 3'h3;
        @(posedge core_clk);
        excReq <= 1'h0;
        clkEn <= 1'h1;
        @(negedge core_clk);
        chk(frameWords, 4'h6);
        // Move faults after one, six, eleven and sixteen transfers, then a plain instruction fault.
        for (int n = 1; n <= 16; n += 5) begin
            fault(2'h1, n, 1'h0);
            chk(savedCount, 16 - n);
            chk(savedStatus[15:14], 2'h1);
            chk(frameWords, 4'hC);
        end
        fault(2'h0, 0, 1'h0);
        chk(savedStatus[15:14], 2'h0);
        // Faults in exception processing, on vector fetch and on stacking, with a stalling acceptor.
        for (int v = 1; v >= 0; v--) begin
            fault(2'h2, 0, v[0]);
            q.push_back({8'h0C, 16'h0, preSr});
            q.push_back({8'h0E, 16'h0, fmtVec});
            q.push_back({8'h10, faultPc});
            q.push_back({8'h02, retPc});
            chk(savedStatus[15:14], 2'h2);
            chk(busy, 1'h1);
            chk(savedFaultAddr, v ? fvWordAddr : curSp);
            for (t = 0; t < 40 && q.size() > 0; t++) begin
                if (frmWrValid && frmWrReady) begin
                    chk({frmWrOfs, frmWrData}, q.pop_front());
                end
                @(posedge core_clk);
                frmWrReady <= rnd() > 16'h8000;
                @(negedge core_clk);
            end
            if (q.size() > 0) begin
                $display("FAIL %0t frame words not all accepted", $time);
                miscompares++;
                stop_test();
            end
            chk(frmWrValid, 1'h0);
            chk(busy, 1'h0);
        end
        // Every combination of the four status flags that a return looks at.
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            excRetReq <= 1'h1;
            retStatus <= {i[3], i[2], 4'h0, i[1], 2'h0, i[0], 6'h0};
            retCount <= 8'(rnd() % 17);
            @(posedge core_clk);
            excRetReq <= 1'h0;
            for (int k = 1; k <= 5; k++) begin
                @(negedge core_clk);
                e = 7'h0;
                if (i[3]) begin
                    e = (k == 2) ? 7'h04 : (k == 3) ? 7'h02 : (k == 4) ? 7'h01 : 7'h0;
                end else if (k == 2) begin
                    e = {i[1], 6'h0};
                end else if (k == 3) begin
                    e = i[2] ? 7'h08 : 7'h30;
                end
                chk(retPulses, e);
                if (!i[3] && i[1] && k == 2) chk(rerunDiscard, i[0]);
                if (i[3:2] == 2'h1 && k == 3) chk(rescanCount, 5'(16 - retCount));
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
